// File: rtl/cpu_exec_pkg.sv
/*
  Shared definitions for the 8-bit execution core: register map,
  reset values, opcode groups, function codes and the structs that
  carry flags, instructions and unit results.
  Assumes a 32-bit classic Wishbone bus with 12 byte-address bits.
*/
package cpu_exec_pkg;

  // five condition flags, stored and read back in this bit order
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } flags_t;

  // one instruction as software hands it over: opcode, then operand bytes
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  } instr_t;

  // result of one arithmetic/logic unit pass
  typedef struct packed {
    logic [7:0] res;
    flags_t fl;
    logic wr;
  } alu_out_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } exec_state_t;

  // register byte offsets
  localparam logic [11:0] OFS_ACC = 12'h000;
  localparam logic [11:0] OFS_IDX = 12'h004;
  localparam logic [11:0] OFS_FLAGS = 12'h008;
  localparam logic [11:0] OFS_PC = 12'h00c;
  localparam logic [11:0] OFS_INSTR = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  // page-0 memory window: 0x400..0x7fc, one byte per word
  localparam logic [1:0] MEM_WIN = 2'h1;
  localparam int MEM_HI = 11;
  localparam int MEM_LO = 10;
  localparam int MIX_HI = 9;
  localparam int MIX_LO = 2;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_PEND = 1;

  // reset values; the mask flag comes up set
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam flags_t FLAGS_RST = 5'h08;
  localparam instr_t INSTR_RST = 24'h000000;

  // execution lengths in clock cycles, and the product opcode that takes the long one
  localparam logic [3:0] CYC_PRODUCT = 4'hb;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [7:0] OP_PRODUCT = 8'h42;

  // instruction lengths in bytes
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  // opcode groups (upper nibble)
  localparam logic [3:0] G_BRBIT = 4'h0;
  localparam logic [3:0] G_BITOP = 4'h1;
  localparam logic [3:0] G_BRANCH = 4'h2;
  localparam logic [3:0] G_RMW_DIR = 4'h3;
  localparam logic [3:0] G_RMW_A = 4'h4;
  localparam logic [3:0] G_RMW_X = 4'h5;
  localparam logic [3:0] G_RMW_IX1 = 4'h6;
  localparam logic [3:0] G_RMW_IX = 4'h7;
  localparam logic [3:0] G_CTRL = 4'h9;
  localparam logic [3:0] G_IMM = 4'ha;
  localparam logic [3:0] G_DIR = 4'hb;
  localparam logic [3:0] G_EXT = 4'hc;
  localparam logic [3:0] G_IX2 = 4'hd;
  localparam logic [3:0] G_IX1 = 4'he;
  localparam logic [3:0] G_IX = 4'hf;

  // read-modify-write functions (lower nibble)
  localparam logic [3:0] F_NEG = 4'h0;
  localparam logic [3:0] F_COM = 4'h3;
  localparam logic [3:0] F_LSR = 4'h4;
  localparam logic [3:0] F_ROR = 4'h6;
  localparam logic [3:0] F_ASR = 4'h7;
  localparam logic [3:0] F_LSL = 4'h8;
  localparam logic [3:0] F_ROL = 4'h9;
  localparam logic [3:0] F_DEC = 4'ha;
  localparam logic [3:0] F_INC = 4'hc;
  localparam logic [3:0] F_TESTONLY = 4'hd;
  localparam logic [3:0] F_CLR = 4'hf;

  // register/memory functions (lower nibble)
  localparam logic [3:0] F_SUB = 4'h0;
  localparam logic [3:0] F_CMP = 4'h1;
  localparam logic [3:0] F_SBC = 4'h2;
  localparam logic [3:0] F_CPX = 4'h3;
  localparam logic [3:0] F_AND = 4'h4;
  localparam logic [3:0] F_BIT = 4'h5;
  localparam logic [3:0] F_LDA = 4'h6;
  localparam logic [3:0] F_STA = 4'h7;
  localparam logic [3:0] F_EOR = 4'h8;
  localparam logic [3:0] F_ADC = 4'h9;
  localparam logic [3:0] F_ORA = 4'ha;
  localparam logic [3:0] F_ADD = 4'hb;
  localparam logic [3:0] F_GOTO = 4'hc;
  localparam logic [3:0] F_CALL = 4'hd;
  localparam logic [3:0] F_LDX = 4'he;
  localparam logic [3:0] F_STX = 4'hf;

  // control functions (lower nibble)
  localparam logic [3:0] C_TAX = 4'h7;
  localparam logic [3:0] C_CLC = 4'h8;
  localparam logic [3:0] C_SEC = 4'h9;
  localparam logic [3:0] C_CLI = 4'ha;
  localparam logic [3:0] C_SEI = 4'hb;
  localparam logic [3:0] C_TXA = 4'hf;

  // byte length of an instruction from its opcode group
  function automatic logic [1:0] instr_len(logic [7:0] op);
    case (op[7:4])
      G_BRBIT, G_EXT, G_IX2: instr_len = LEN3;
      G_BITOP, G_BRANCH, G_RMW_DIR, G_RMW_IX1, G_IMM, G_DIR, G_IX1: instr_len = LEN2;
      default: instr_len = LEN1;
    endcase
  endfunction : instr_len

endpackage : cpu_exec_pkg

// File: rtl/cpu_exec.sv
/*
  Execution core of an 8-bit controller: accumulator, index register,
  flag register, program counter, a 256-byte page-0 memory and the
  instruction semantics. Software loads an instruction over Wishbone
  and the core executes it against its own state.
  Assumes a classic Wishbone master on mclk_i and an asynchronous
  active-low interrupt request pin.
*/
// The register offsets and the Wishbone register port were decided locally.
// How it works
// - flag register is five bits wide
// - add sets nibble carry from bit 3
// - mask flag set blocks interrupt service
// - masked interrupt stays pending until unmasked
// - sign flag follows result top bit
// - zero flag set on zero result
// - carry flag tracks arithmetic carry or borrow
// - shifts, rotates, bit branches also set carry
// - product of index and accumulator, high in index
// - product clears nibble carry and carry only
// - product opcode 42 hex, eleven cycles
// - conditional branches are two bytes
// - untaken branch only advances past itself
// - bit set/clear reach all of page 0
// - bit branch copies tested bit to carry
// - read-modify-write writes result back in place
// - test-without-write updates flags, writes nothing
// - first operand register, second from memory
// - goto and call use only the target address
// - instructions are one to three bytes
`timescale 1ns/10ps
module cpu_exec
  import cpu_exec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic irq_n_i,
  output logic int_service_o
);

  // per-lane merge of a bus write into the current word
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
    for (int k = 0; k < 4; k++) begin
      merge[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
    end
  endfunction : merge

  // operand address from opcode group and operand bytes
  function automatic logic [15:0] locate(instr_t s, logic [7:0] x);
    case (s.op[7:4])
      G_RMW_IX1, G_IX1: locate = {8'h00, s.b1} + {8'h00, x};
      G_RMW_IX, G_IX: locate = {8'h00, x};
      G_EXT: locate = {s.b1, s.b2};
      G_IX2: locate = {s.b1, s.b2} + {8'h00, x};
      default: locate = {8'h00, s.b1};
    endcase
  endfunction : locate

  // read-modify-write unit
  function automatic alu_out_t do_rmw(logic [3:0] f, logic [7:0] v, flags_t fl);
    alu_out_t o;
    logic known;
    o.res = v;
    o.fl = fl;
    o.wr = 1'b1;
    known = 1'b1;
    case (f)
      F_NEG: begin
        o.res = 8'h00 - v;
        o.fl.c = |o.res;
      end
      F_COM: begin
        o.res = ~v;
        o.fl.c = 1'b1;
      end
      F_LSR: begin
        o.res = {1'b0, v[7:1]};
        o.fl.c = v[0];
      end
      F_ROR: begin
        o.res = {fl.c, v[7:1]};
        o.fl.c = v[0];
      end
      F_ASR: begin
        o.res = {v[7], v[7:1]};
        o.fl.c = v[0];
      end
      F_LSL: begin
        o.res = {v[6:0], 1'b0};
        o.fl.c = v[7];
      end
      F_ROL: begin
        o.res = {v[6:0], fl.c};
        o.fl.c = v[7];
      end
      F_DEC: o.res = v - 8'h01;
      F_INC: o.res = v + 8'h01;
      F_TESTONLY: o.wr = 1'b0;
      F_CLR: o.res = 8'h00;
      default: begin
        o.wr = 1'b0;
        known = 1'b0;
      end
    endcase
    if (known) begin
      o.fl.n = o.res[7];
      o.fl.z = (o.res == 8'h00);
    end
    return o;
  endfunction : do_rmw

  // register/memory unit; wr means the register takes the result
  function automatic alu_out_t do_regmem(logic [3:0] f, logic [7:0] r, logic [7:0] m, flags_t fl);
    alu_out_t o;
    logic [8:0] s;
    logic [4:0] hs;
    logic cy;
    o.res = r;
    o.fl = fl;
    o.wr = 1'b1;
    cy = (f == F_ADC || f == F_SBC) && fl.c;
    case (f)
      F_ADD, F_ADC: begin
        s = {1'b0, r} + {1'b0, m} + {8'h00, cy};
        hs = {1'b0, r[3:0]} + {1'b0, m[3:0]} + {4'h0, cy};
        o.res = s[7:0];
        o.fl.h = hs[4];
        o.fl.c = s[8];
      end
      F_SUB, F_SBC, F_CMP, F_CPX: begin
        s = {1'b0, r} - {1'b0, m} - {8'h00, cy};
        o.res = s[7:0];
        o.fl.c = s[8];
        o.wr = (f == F_SUB || f == F_SBC);
      end
      F_AND, F_BIT: begin
        o.res = r & m;
        o.wr = (f == F_AND);
      end
      F_EOR: o.res = r ^ m;
      F_ORA: o.res = r | m;
      F_LDA, F_LDX: o.res = m;
      F_STA, F_STX: o.wr = 1'b0;
      default: o.wr = 1'b0;
    endcase
    o.fl.n = o.res[7];
    o.fl.z = (o.res == 8'h00);
    return o;
  endfunction : do_regmem

  // relative-branch condition; odd opcodes take the inverse
  function automatic logic br_cond(logic [7:0] op, flags_t fl, logic pin);
    logic base;
    case (op[3:1])
      3'h0: base = 1'b1;
      3'h1: base = ~(fl.c | fl.z);
      3'h2: base = ~fl.c;
      3'h3: base = ~fl.z;
      3'h4: base = ~fl.h;
      3'h5: base = ~fl.n;
      3'h6: base = ~fl.i;
      default: base = ~pin;
    endcase
    return base ^ op[0];
  endfunction : br_cond

  logic [7:0] acc_reg, acc_next, idx_reg, idx_next;
  logic [15:0] pc_reg, pc_next;
  flags_t flg_reg, flg_next;
  instr_t ins_reg, ins_next;
  exec_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ack_reg, svc_reg, pend_reg;
  logic [31:0] dat_reg;
  logic irq_s1_reg, irq_s2_reg, irq_s3_reg;
  logic [7:0] mem_q [256];

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire idle = (state_reg == ST_IDLE);
  wire bus_wr = req & wb_we_i & ack_reg & idle; // writes while busy are dropped
  wire hit_acc = (wb_adr_i == OFS_ACC);
  wire hit_idx = (wb_adr_i == OFS_IDX);
  wire hit_flg = (wb_adr_i == OFS_FLAGS);
  wire hit_pc = (wb_adr_i == OFS_PC);
  wire hit_ins = (wb_adr_i == OFS_INSTR);
  wire hit_st = (wb_adr_i == OFS_STATUS);
  wire hit_mem = (wb_adr_i[MEM_HI:MEM_LO] == MEM_WIN);
  wire [7:0] bus_ix = wb_adr_i[MIX_HI:MIX_LO];
  wire [31:0] status_w = {30'h0, pend_reg, ~idle};

  // read mux; unmapped addresses read zero
  wire [31:0] rd_data = hit_mem ? {24'h0, mem_q[bus_ix]} :
                        hit_acc ? {24'h0, acc_reg} :
                        hit_idx ? {24'h0, idx_reg} :
                        hit_flg ? {27'h0, flg_reg} :
                        hit_pc ? {16'h0, pc_reg} :
                        hit_ins ? {8'h00, ins_reg} :
                        hit_st ? status_w : 32'h0;
  wire [31:0] wmerged = merge(rd_data, wb_dat_i, wb_sel_i);

  // operand fetch; the memory holds page 0 only, so higher addresses alias into it
  wire [3:0] grp = ins_reg.op[7:4];
  wire [3:0] fn = ins_reg.op[3:0];
  wire [15:0] loc = locate(ins_reg, idx_reg);
  wire [7:0] mval = mem_q[loc[7:0]];
  wire [2:0] bitno = ins_reg.op[3:1];
  wire tbit = mval[bitno];
  wire [1:0] len = instr_len(ins_reg.op);
  wire use_x = (fn == F_CPX || fn == F_LDX || fn == F_STX);
  wire [7:0] rmw_opnd = (grp == G_RMW_A) ? acc_reg : (grp == G_RMW_X) ? idx_reg : mval;
  wire [7:0] rm_opnd = (grp == G_IMM) ? ins_reg.b1 : mval;
  wire [15:0] product = {8'h00, idx_reg} * {8'h00, acc_reg};
  wire alu_out_t rw = do_rmw(fn, rmw_opnd, flg_reg);
  wire alu_out_t rm = do_regmem(fn, use_x ? idx_reg : acc_reg, rm_opnd, flg_reg);
  wire br_take = br_cond(ins_reg.op, flg_reg, irq_s2_reg);
  wire commit = (state_reg == ST_EXEC) && (cnt_reg == CYC_ONE);

  // interrupt: falling edge of the synced pin latches a request
  wire irq_event = irq_s3_reg & ~irq_s2_reg;
  wire take = pend_reg & ~flg_reg.i & idle & ~(req & wb_we_i & ack_reg);

  logic [7:0] acc_x, idx_x, mem_wd;
  logic [15:0] pc_x;
  flags_t fl_x;
  logic mem_we;

  // instruction semantics, applied at the commit edge
  always_comb begin
    acc_x = acc_reg;
    idx_x = idx_reg;
    fl_x = flg_reg;
    mem_wd = mval;
    mem_we = 1'b0;
    pc_x = pc_reg + {14'h0, len};
    unique case (grp)
      G_BRBIT: begin
        fl_x.c = tbit;
        if (tbit ^ ins_reg.op[0]) begin
          pc_x = pc_x + {{8{ins_reg.b2[7]}}, ins_reg.b2};
        end
      end
      G_BITOP: begin
        mem_wd[bitno] = ~ins_reg.op[0];
        mem_we = 1'b1;
      end
      G_BRANCH: begin
        if (br_take) begin
          pc_x = pc_x + {{8{ins_reg.b1[7]}}, ins_reg.b1};
        end
      end
      G_RMW_DIR, G_RMW_A, G_RMW_X, G_RMW_IX1, G_RMW_IX: begin
        if (ins_reg.op == OP_PRODUCT) begin
          {idx_x, acc_x} = product;
          fl_x.h = 1'b0;
          fl_x.c = 1'b0;
        end else begin
          fl_x = rw.fl;
          if (rw.wr && grp == G_RMW_A) begin
            acc_x = rw.res;
          end else if (rw.wr && grp == G_RMW_X) begin
            idx_x = rw.res;
          end else begin
            mem_wd = rw.res;
            mem_we = rw.wr;
          end
        end
      end
      G_CTRL: begin
        case (fn)
          C_TAX: idx_x = acc_reg;
          C_TXA: acc_x = idx_reg;
          C_CLC: fl_x.c = 1'b0;
          C_SEC: fl_x.c = 1'b1;
          C_CLI: fl_x.i = 1'b0;
          C_SEI: fl_x.i = 1'b1;
          default: ; // stack and sleep controls live outside this core
        endcase
      end
      G_IMM, G_DIR, G_EXT, G_IX2, G_IX1, G_IX: begin
        if (fn == F_GOTO || fn == F_CALL) begin
          pc_x = loc;
        end else begin
          fl_x = rm.fl;
          if (fn == F_STA || fn == F_STX) begin
            mem_wd = rm.res;
            mem_we = (grp != G_IMM);
          end else if (rm.wr && use_x) begin
            idx_x = rm.res;
          end else if (rm.wr) begin
            acc_x = rm.res;
          end
        end
      end
      default: ; // unused opcode groups execute as no operation
    endcase
  end

  // next state: execution commit, else bus write, else interrupt entry
  always_comb begin
    acc_next = acc_reg;
    idx_next = idx_reg;
    flg_next = flg_reg;
    pc_next = pc_reg;
    ins_next = ins_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (state_reg == ST_EXEC) begin
      cnt_next = cnt_reg - CYC_ONE;
    end
    if (commit) begin
      acc_next = acc_x;
      idx_next = idx_x;
      flg_next = fl_x;
      pc_next = pc_x;
      state_next = ST_IDLE;
    end else if (bus_wr) begin
      if (hit_acc) acc_next = wmerged[7:0];
      if (hit_idx) idx_next = wmerged[7:0];
      if (hit_flg) flg_next = flags_t'(wmerged[4:0]);
      if (hit_pc) pc_next = wmerged[15:0];
      if (hit_ins) begin
        ins_next = instr_t'(wmerged[23:0]);
        state_next = ST_EXEC;
        cnt_next = (wmerged[23:16] == OP_PRODUCT) ? CYC_PRODUCT : CYC_ONE;
      end
    end else if (take) begin
      flg_next.i = 1'b1; // entry masks further requests
    end
  end

  // core registers and bus handshake
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      acc_reg <= ACC_RST;
      idx_reg <= IDX_RST;
      flg_reg <= FLAGS_RST;
      pc_reg <= PC_RST;
      ins_reg <= INSTR_RST;
      state_reg <= ST_IDLE;
      cnt_reg <= CYC_ONE;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      svc_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      idx_reg <= idx_next;
      flg_reg <= flg_next;
      pc_reg <= pc_next;
      ins_reg <= ins_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ack_reg <= req & ~ack_reg;
      dat_reg <= (req & ~ack_reg) ? rd_data : dat_reg;
      svc_reg <= take;
    end
  end

  // pin synchroniser and pending latch; a new edge beats the clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_s1_reg <= 1'b1;
      irq_s2_reg <= 1'b1;
      irq_s3_reg <= 1'b1;
      pend_reg <= 1'b0;
    end else begin
      irq_s1_reg <= irq_n_i;
      irq_s2_reg <= irq_s1_reg;
      irq_s3_reg <= irq_s2_reg;
      pend_reg <= irq_event | (pend_reg & ~take);
    end
  end

  // page-0 memory: no reset, contents are software's
  always_ff @(posedge mclk_i) begin
    if (commit && mem_we) begin
      mem_q[loc[7:0]] <= mem_wd;
    end else if (bus_wr && hit_mem && wb_sel_i[0]) begin
      mem_q[bus_ix] <= wb_dat_i[7:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign int_service_o = svc_reg;

endmodule : cpu_exec

// File: verification/cpu_exec_asserts.sv
/*
  checker for the execution core: bus handshake, read data holding,
  flag width and interrupt entry.
  assumes it is bound to cpu_exec and sees only its ports.
*/
`timescale 1ns/10ps
module cpu_exec_asserts
  import cpu_exec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_n_i,
  input wire logic int_service_o
);
  logic armed_reg;
  logic armed_next;
  // entry sets the mask, so a mask-clearing flag write or an instruction must come between two services;
  // a flag write that sets the mask disarms again
  assign armed_next = (wb_ack_o && wb_we_i && wb_adr_i == OFS_FLAGS) ? !wb_dat_i[3] :
                      (wb_ack_o && wb_we_i && wb_adr_i == OFS_INSTR) ? 1'b1 : (armed_reg && !int_service_o);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) armed_reg <= 1'b0;
    else armed_reg <= armed_next;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_dat_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved outside an access");
  a_flags_five_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_FLAGS |-> wb_dat_o[31:5] == 27'h0)
    else $error("flag read wider than five bits");
  a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:10] == 2'h0 && wb_adr_i > OFS_STATUS
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_serv_one_cycle: assert property (int_service_o |=> !int_service_o)
    else $error("service pulse too long");
  a_serv_needs_write: assert property (int_service_o |-> armed_reg)
    else $error("service while mask still set");
  a_serv_not_in_write: assert property (int_service_o |-> !($past(wb_ack_o) && $past(wb_we_i)))
    else $error("service entered during a write");
endmodule : cpu_exec_asserts

bind cpu_exec cpu_exec_asserts cpu_exec_asserts_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_n_i(irq_n_i), .int_service_o(int_service_o));

// File: verification/cpu_exec_bench.sv
/*
  self-checking bench for the execution core: flags, add, product,
  branches, page-0 bits, read-modify-write and interrupt masking.
  assumes a classic wishbone slave answering within a few cycles.
*/
`timescale 1ns/10ps
module cpu_exec_bench;
  import cpu_exec_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_n_i = 1'b1;
  logic int_service_o;
  int n_errors = 0;
  int num_checks = 0;
  int n_serv = 0;

  cpu_exec cpu_exec_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_n_i(irq_n_i), .int_service_o(int_service_o));

  always #10 mclk_i = ~mclk_i;
  // counts accepted interrupts so masking can be judged afterwards
  always @(posedge mclk_i) if (int_service_o === 1'b1) n_serv++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; the leading edge keeps the idle gap between accesses
  task automatic wb_access(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_access

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_access(1'b1, a, d, q);
  endtask : wr

  task automatic expect_reg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_access(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : expect_reg

  function automatic logic [11:0] mem(input logic [7:0] n);
    return {2'h1, n, 2'h0};
  endfunction : mem

  task automatic run(input logic [23:0] ins);
    wr(OFS_INSTR, {8'h00, ins});
  endtask : run

  task automatic t_reset;
    expect_reg(OFS_FLAGS, 32'h08);
    expect_reg(OFS_ACC, 32'h0);
    wr(OFS_FLAGS, 32'hffffffff);
    expect_reg(OFS_FLAGS, 32'h1f);
    wr(12'h100, 32'hff);
    expect_reg(12'h100, 32'h0);
  endtask : t_reset

  task automatic t_add;
    logic [31:0] q;
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_ACC, 32'h0f);
    run(24'hab0100);
    expect_reg(OFS_ACC, 32'h10);
    expect_reg(OFS_FLAGS, 32'h10);
    wr(OFS_ACC, 32'hff);
    run(24'hab0100);
    expect_reg(OFS_FLAGS, 32'h13);
    wr(OFS_FLAGS, 32'h01);
    wr(OFS_ACC, 32'h07);
    run(24'ha90800);
    expect_reg(OFS_ACC, 32'h10);
    expect_reg(OFS_FLAGS, 32'h10);
    wr(OFS_ACC, 32'h00);
    run(24'ha00100);
    wb_access(1'b0, OFS_FLAGS, 32'h0, q);
    check(q & 32'h7, 32'h5);
  endtask : t_add

  // busy is sampled two edges after acceptance, then ten, then thirteen
  task automatic t_product;
    wr(OFS_FLAGS, 32'h1f);
    wr(OFS_IDX, 32'hc8);
    wr(OFS_ACC, 32'h64);
    run({OP_PRODUCT, 16'h0});
    expect_reg(OFS_STATUS, 32'h1);
    repeat (5) @(posedge mclk_i);
    expect_reg(OFS_STATUS, 32'h1);
    expect_reg(OFS_STATUS, 32'h0);
    expect_reg(OFS_IDX, 32'h4e);
    expect_reg(OFS_ACC, 32'h20);
    expect_reg(OFS_FLAGS, 32'h0e);
  endtask : t_product

  task automatic t_branch;
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_PC, 32'h100);
    run(24'h271000);
    expect_reg(OFS_PC, 32'h102);
    wr(OFS_PC, 32'h100);
    wr(OFS_FLAGS, 32'h02);
    run(24'h271000);
    expect_reg(OFS_PC, 32'h112);
    wr(OFS_PC, 32'h100);
    run(24'h211000);
    expect_reg(OFS_PC, 32'h102);
  endtask : t_branch

  task automatic t_bits;
    wr(mem(8'hff), 32'h0);
    run(24'h1eff00);
    expect_reg(mem(8'hff), 32'h80);
    run(24'h1fff00);
    expect_reg(mem(8'hff), 32'h0);
    wr(mem(8'h10), 32'h01);
    wr(OFS_PC, 32'h200);
    wr(OFS_FLAGS, 32'h0);
    run(24'h001020);
    expect_reg(OFS_PC, 32'h223);
    expect_reg(OFS_FLAGS, 32'h01);
  endtask : t_bits

  task automatic t_rmw;
    wr(mem(8'h05), 32'h7f);
    wr(OFS_FLAGS, 32'h0);
    run(24'h3c0500);
    expect_reg(mem(8'h05), 32'h80);
    expect_reg(OFS_FLAGS, 32'h04);
    wr(OFS_FLAGS, 32'h02);
    run(24'h3d0500);
    expect_reg(mem(8'h05), 32'h80);
    expect_reg(OFS_FLAGS, 32'h04);
    wr(OFS_ACC, 32'h01);
    wr(OFS_PC, 32'h300);
    run(24'h440000);
    expect_reg(OFS_FLAGS, 32'h03);
    expect_reg(OFS_PC, 32'h301);
    run(24'hb60500);
    expect_reg(OFS_ACC, 32'h80);
    run(24'hbe0500);
    expect_reg(OFS_IDX, 32'h80);
    run(24'hcc1234);
    expect_reg(OFS_PC, 32'h1234);
    expect_reg(OFS_ACC, 32'h80);
  endtask : t_rmw

  task automatic t_irq;
    wr(OFS_FLAGS, 32'h08);
    irq_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    expect_reg(OFS_STATUS, 32'h2);
    check(n_serv, 32'h0);
    irq_n_i <= 1'b1;
    wr(OFS_FLAGS, 32'h0);
    repeat (6) @(posedge mclk_i);
    check(n_serv, 32'h1);
    expect_reg(OFS_FLAGS, 32'h08);
    expect_reg(OFS_STATUS, 32'h0);
  endtask : t_irq

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_add;
    t_product;
    t_branch;
    t_bits;
    t_rmw;
    t_irq;
    give_verdict;
  end
endmodule : cpu_exec_bench
